//--- logic/ricar_bank.sv
`timescale 1ns/1ps
`default_nettype none
//Function
//RULE1: Identity register bits 0:15, the high-order half, hold read-only 16-bit part code.
//RULE2: Identity register bits 16:31, the low-order half, hold read-only 16-bit maker code.
//RULE3: Revision register bits 24:27 hold die revision; bits 0:23 read zero.
//RULE4: Revision register bits 28:31 hold metal layer revision.
//RULE5: Board type and board revision fields, bits 0:15, accept EEPROM preload.
//RULE6: Board maker field, bits 16:31 of assembly identity, accepts EEPROM preload.
//RULE7: Assembly info bits 16:31 read feature list pointer 0x0100.
//RULE8: All registers are 32-bit, read-only, whole words, big-endian numbering.
//RULE9: Preload runs after power-on reset and after self-reset completes.
//RULE10: Writes change nothing; reads return whole word without side effects.
module ricar_bank
  import ricar_pkg::*;
#(
  parameter logic [15:0] PART_CODE   = 16'h1234, // Arbitrary value.
  parameter logic [15:0] MAKER_CODE  = 16'h00aa, // Arbitrary value.
  parameter logic [3:0]  DIE_REV     = 4'h3,     // Arbitrary value.
  parameter logic [3:0]  LAYER_REV   = 4'h6      // Arbitrary value.
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        self_reset_done_i,
  input  wire logic        preload_valid_i,
  input  wire ricar_asm_t  preload_i,
  input  wire ricar_mreq_t mreq_i,
  output ricar_mrsp_t      mrsp_o,
  output logic             preload_open_o
);

  ricar_state_t            state;
  ricar_state_t            next_state;
  ricar_asm_t              board;
  logic [NUM_REGS-1:0][31:0] words;
  logic                    hit;
  logic                    rd_take;
  logic                    bus_ack;
  logic                    bus_err;
  logic [31:0]             rom_data;
  logic [1:0]              index;

  // One image of the assembly fields after reset, shared by the load logic and its checks.
  localparam ricar_asm_t BOARD_RESET = '{RST_BOARD_TYPE, RST_BOARD_MAKER, RST_BOARD_REVISION};

  // The word assembly below fills exactly four 32-bit words and decodes address bits 3:2.
  if (NUM_REGS != 4 || DATA_W != 32 || ADDR_W < 4) begin : g_bad_layout
    $error("ricar_bank serves four 32-bit words only");
  end

  function automatic logic decode_hit(input logic [ADDR_W-1:0] a);
    decode_hit = (a == OFS_DEVICE_IDENTITY) || (a == OFS_DEVICE_REVISION_INFO) ||
                 (a == OFS_ASSEMBLY_IDENTITY) || (a == OFS_ASSEMBLY_INFO);
  endfunction : decode_hit

  // A write or an unmapped offset never loads the store, so the last read word stays on the bus.
  assign hit     = decode_hit(mreq_i.addr);
  assign rd_take = mreq_i.req && !mreq_i.wr && hit;
  assign index   = mreq_i.addr[3:2];

  // Preload window opens after reset or self-reset and closes on the first loaded value.
  always_comb begin
    next_state = state;
    case (state)
      RICAR_WAIT_LOAD: if (preload_valid_i) next_state = RICAR_READY;
      RICAR_READY:     if (self_reset_done_i) next_state = RICAR_WAIT_LOAD; // [RULE9]
      default:         next_state = RICAR_WAIT_LOAD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= RICAR_WAIT_LOAD; // [RULE9]
    end else begin
      state <= next_state;
    end
  end

  // Self-reset restores the reset values before a new preload; the bus can never write here.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || (state == RICAR_READY && self_reset_done_i)) begin
      board <= BOARD_RESET; // [RULE9]
    end else if (state == RICAR_WAIT_LOAD && preload_valid_i) begin
      board <= preload_i; // [RULE5] [RULE6] [RULE9]
    end
  end

  assign preload_open_o = (state == RICAR_WAIT_LOAD);

  // Big-endian bit 0 is vector bit 31, so a field at big-endian bits 0:15 sits in the high half.
  always_comb begin
    words = '0; // [RULE3]
    words[0][HI_FIELD_LSB +: 16] = PART_CODE; // [RULE1]
    words[0][LO_FIELD_LSB +: 16] = MAKER_CODE; // [RULE2]
    words[1][DIE_REV_LSB +: 4]   = DIE_REV; // [RULE3]
    words[1][LAYER_REV_LSB +: 4] = LAYER_REV; // [RULE4]
    words[2][HI_FIELD_LSB +: 16] = board.board_type_field; // [RULE5]
    words[2][LO_FIELD_LSB +: 16] = board.board_maker_field; // [RULE6]
    words[3][HI_FIELD_LSB +: 16] = board.board_revision_field; // [RULE5]
    words[3][LO_FIELD_LSB +: 16] = FEATURE_LIST_POINTER; // [RULE7]
  end

  ricar_rom #(
    .DEPTH (NUM_REGS)
  ) u_rom (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .words_i (words),
    .index_i (index),
    .rd_i    (rd_take), // [RULE8]
    .rdata_o (rom_data)
  );

  // Writes are acknowledged but discarded; unmapped offsets answer with an error flag.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
    end else begin
      bus_ack <= mreq_i.req; // [RULE10]
      bus_err <= mreq_i.req && !hit;
    end
  end

  assign mrsp_o = '{ack: bus_ack, err: bus_err, rdata: rom_data};

  // Read-path checks compare against the documented field layout, not against the words array.
  a_part_maker_word: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE1]
    (mreq_i.req && !mreq_i.wr && mreq_i.addr == OFS_DEVICE_IDENTITY)
      |=> mrsp_o.rdata[31:16] == PART_CODE && mrsp_o.rdata[15:0] == MAKER_CODE)
    else $error("identity word wrong");

  a_maker_half: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE2]
    (rd_take && index == 2'h0)
      |=> mrsp_o.ack && mrsp_o.rdata[15:0] == MAKER_CODE)
    else $error("maker code wrong");

  a_rev_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE3]
    (rd_take && index == 2'h1)
      |=> mrsp_o.rdata[31:8] == 24'h00_0000 && mrsp_o.rdata[7:4] == DIE_REV)
    else $error("revision reserved bits not zero");

  a_layer_rev: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE4]
    (rd_take && index == 2'h1)
      |=> mrsp_o.rdata[3:0] == LAYER_REV)
    else $error("layer revision wrong");

  a_preload_taken: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE5]
    (preload_open_o && preload_valid_i)
      |=> board == $past(preload_i) && !preload_open_o)
    else $error("preload not taken");

  a_maker_preload_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE6]
    (rd_take && index == 2'h2)
      |=> mrsp_o.rdata == {$past(board.board_type_field), $past(board.board_maker_field)})
    else $error("assembly identity word wrong");

  a_revision_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE5]
    (rd_take && index == 2'h3)
      |=> mrsp_o.rdata[31:16] == $past(board.board_revision_field))
    else $error("assembly revision wrong");

  a_feature_pointer: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE7]
    (rd_take && index == 2'h3)
      |=> mrsp_o.rdata[15:0] == FEATURE_LIST_POINTER)
    else $error("feature pointer wrong");

  a_read_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE8]
    mreq_i.req
      |=> mrsp_o.ack ##1 (!mrsp_o.ack || $past(mreq_i.req)))
    else $error("answer latency wrong");

  a_no_stray_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE8]
    !mreq_i.req
      |=> !mrsp_o.ack)
    else $error("answer without request");

  a_self_reset_reopen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
    (state == RICAR_READY && self_reset_done_i)
      |=> preload_open_o && board == BOARD_RESET)
    else $error("self-reset did not reopen preload");

  a_closed_preload: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
    (state == RICAR_READY && preload_valid_i && !self_reset_done_i)
      |=> $stable(board) && !preload_open_o)
    else $error("preload taken while window closed");

  // This check runs through reset on purpose, so it carries no disable condition.
  a_reset_reopen: assert property (@(posedge clk_i) // [RULE9]
    !rst_n_i
      |=> preload_open_o && board == BOARD_RESET && !mrsp_o.ack && mrsp_o.rdata == 32'h0000_0000)
    else $error("reset did not restore the bank");

  // Bus writes have no path into the bank; these checks would catch one that slipped in.
  a_write_no_change: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
    (mreq_i.req && mreq_i.wr && !preload_valid_i && !self_reset_done_i)
      |=> $stable(board) && $stable(mrsp_o.rdata))
    else $error("write changed contents");

  a_unmapped_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
    (mreq_i.req && !hit)
      |=> mrsp_o.ack && mrsp_o.err && $stable(mrsp_o.rdata))
    else $error("unmapped offset answered wrongly");

  a_mapped_no_err: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
    (mreq_i.req && hit)
      |=> mrsp_o.ack && !mrsp_o.err)
    else $error("mapped offset flagged as error");

  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
    !rd_take
      |=> $stable(mrsp_o.rdata))
    else $error("read data changed without a read");

  // Covers mark the scenarios that the bench is meant to reach.
  c_read_identity: cover property (@(posedge clk_i) rd_take && index == 2'h0);
  c_preload:       cover property (@(posedge clk_i) preload_open_o && preload_valid_i);
  c_write_try:     cover property (@(posedge clk_i) mreq_i.req && mreq_i.wr);
  c_unmapped:      cover property (@(posedge clk_i) mrsp_o.err);
  c_self_reset:    cover property (@(posedge clk_i) state == RICAR_READY && self_reset_done_i);

endmodule : ricar_bank
`default_nettype wire

//--- logic/ricar_pkg.sv
package ricar_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_DEVICE_IDENTITY      = 20'h00000;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_REVISION_INFO = 20'h00004;
  localparam logic [ADDR_W-1:0] OFS_ASSEMBLY_IDENTITY    = 20'h00008;
  localparam logic [ADDR_W-1:0] OFS_ASSEMBLY_INFO        = 20'h0000c;

  localparam int NUM_REGS = 4;

  // Field positions are given as bit indices in the little-endian vector; big-endian bit 0 is bit 31 here.
  localparam int HI_FIELD_LSB = 16;
  localparam int LO_FIELD_LSB = 0;
  localparam int DIE_REV_LSB   = 4;
  localparam int LAYER_REV_LSB = 0;

  localparam logic [15:0] FEATURE_LIST_POINTER = 16'h0100;

  // Assembly reset values; an EEPROM preload may replace them.
  localparam logic [15:0] RST_BOARD_TYPE     = 16'h00c3; // Arbitrary value.
  localparam logic [15:0] RST_BOARD_MAKER    = 16'h0000;
  localparam logic [15:0] RST_BOARD_REVISION = 16'h0000;

  // Latency of a maintenance read, in clk_i cycles.
  localparam int READ_LATENCY = 1;

  typedef struct packed {
    logic [15:0] board_type_field;
    logic [15:0] board_maker_field;
    logic [15:0] board_revision_field;
  } ricar_asm_t;

  typedef struct packed {
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ricar_mreq_t;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } ricar_mrsp_t;

  typedef enum logic [1:0] {
    RICAR_WAIT_LOAD,
    RICAR_READY
  } ricar_state_t;

endpackage : ricar_pkg

//--- logic/ricar_rom.sv
`timescale 1ns/1ps
`default_nettype none
// Small word store for the four capability words; read data come out of a register.
module ricar_rom
  import ricar_pkg::*;
#(
  parameter int DEPTH = NUM_REGS
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [DEPTH-1:0][31:0]   words_i,
  input  wire logic [$clog2(DEPTH)-1:0] index_i,
  input  wire logic                     rd_i,
  output logic      [31:0]              rdata_o
);

  // A single word would leave the index port with no bits at all.
  if (DEPTH < 2) begin : g_bad_depth
    $error("ricar_rom needs at least two words");
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= words_i[index_i];
    end
  end

endmodule : ricar_rom
`default_nettype wire

//--- tb/ricar_pe_model.sv
`timescale 1ns/1ps
`default_nettype none
module ricar_pe_model
  import ricar_pkg::*;
(
  input  wire logic        clk_i,
  input  wire ricar_mrsp_t mrsp_i,
  output var  ricar_mreq_t mreq_o
);
  initial mreq_o = '0;
  // The answer is taken one cycle after the request edge; released lines show the inverse of the request.
  task automatic access(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata,
                        output ricar_mrsp_t rsp);
    @(posedge clk_i);
    mreq_o <= '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
    @(posedge clk_i);
    mreq_o <= '{req: 1'b0, wr: ~wr, addr: ~addr, wdata: ~wdata};
    #1;
    rsp = mrsp_i;
  endtask : access
endmodule : ricar_pe_model
`default_nettype wire

//--- tb/rio_identity_car_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rio_identity_car_bank_tb_top;
  import ricar_pkg::*;
  // Identity parameters are arbitrary values, chosen distinct to expose field swaps.
  localparam logic [15:0] P_CODE = 16'h1234;
  localparam logic [15:0] M_CODE = 16'h00aa;
  localparam logic [3:0]  D_REV  = 4'h5;
  localparam logic [3:0]  L_REV  = 4'ha;
  localparam ricar_asm_t  RST_ASM = '{RST_BOARD_TYPE, RST_BOARD_MAKER, RST_BOARD_REVISION};
  localparam ricar_asm_t  NEW_ASM = '{16'h5a01, 16'h3c02, 16'h9603};
  logic        clk_i, rst_n_i, self_reset_done_i, preload_valid_i, preload_open;
  ricar_asm_t  preload_i, cur;
  ricar_mreq_t mreq;
  ricar_mrsp_t mrsp, rsp;
  int          n_fail, total_checks;

  ricar_bank #(.PART_CODE(P_CODE), .MAKER_CODE(M_CODE), .DIE_REV(D_REV), .LAYER_REV(L_REV)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .self_reset_done_i(self_reset_done_i),
    .preload_valid_i(preload_valid_i), .preload_i(preload_i), .mreq_i(mreq), .mrsp_o(mrsp),
    .preload_open_o(preload_open));
  ricar_pe_model pe (.clk_i(clk_i), .mrsp_i(mrsp), .mreq_o(mreq));

  function automatic logic [31:0] exp_word(input int i, input ricar_asm_t a);
    case (i)
      0: return {P_CODE, M_CODE};
      1: return {24'h000000, D_REV, L_REV};
      2: return {a.board_type_field, a.board_maker_field};
      default: return {a.board_revision_field, 16'h0100};
    endcase
  endfunction : exp_word

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_all();
    for (int i = 0; i < 4; i++) begin
      pe.access(1'b0, 20'(i * 4), 32'h00000000, rsp);
      check(rsp.rdata, exp_word(i, cur));
      check({30'h0, rsp.ack, rsp.err}, 32'h2);
    end
  endtask : check_all

  task automatic preload(input ricar_asm_t v);
    @(posedge clk_i);
    preload_valid_i <= 1'b1;
    preload_i       <= v;
    @(posedge clk_i);
    preload_valid_i <= 1'b0;
  endtask : preload

  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // The whole sequence needs about 80 cycles; this allows ten times that.
  initial begin
    #40000;
    $display("ERROR %0t: timeout", $time);
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_n_i = 1'b0;
    self_reset_done_i = 1'b0;
    preload_valid_i = 1'b0;
    preload_i = '0;
    cur = RST_ASM;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    check(mrsp.rdata, 32'h0000_0000);
    check({30'h0, mrsp.ack, mrsp.err}, 32'h0);
    check_all();
    for (int i = 0; i < 4; i++) begin
      pe.access(1'b1, 20'(i * 4), 32'hffffffff, rsp);
      check({31'h0, rsp.err}, 32'h0);
    end
    check_all();
    pe.access(1'b0, 20'h00010, 32'h00000000, rsp);
    check({30'h0, rsp.ack, rsp.err}, 32'h3);
    check(rsp.rdata, exp_word(3, cur));
    check({31'h0, preload_open}, 32'h1);
    preload(NEW_ASM);
    cur = NEW_ASM;
    #1;
    check({31'h0, preload_open}, 32'h0);
    preload(ricar_asm_t'(~NEW_ASM));
    check_all();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cur = RST_ASM;
    #1;
    check({31'h0, preload_open}, 32'h1);
    check(mrsp.rdata, 32'h0000_0000);
    check_all();
    preload(NEW_ASM);
    cur = NEW_ASM;
    check_all();
    @(posedge clk_i);
    self_reset_done_i <= 1'b1;
    @(posedge clk_i);
    self_reset_done_i <= 1'b0;
    cur = RST_ASM;
    #1;
    check({31'h0, preload_open}, 32'h1);
    check_all();
    print_verdict();
  end
endmodule : rio_identity_car_bank_tb_top
`default_nettype wire
